// file: adc_mon_pkg.sv
// Constants, types and register map of the conversion-result monitor
// Contract
// - Comparator uses absolute value of threshold
// - Exceed count reaching limit sets flag, interrupt
// - Exceed counter register reports exceedances so far
// - Accumulator is read only; writes ignored
// - Accumulator updates at most two clocks before result
// - Accumulator overflow wraps silently, no flag
// - Result count limit can restart the accumulator
// - Accumulate signed or unipolar per coding select
// - Accumulator cleared when disabled or ADC reconfigured
// - Accumulator holds running sum, result format
// - Read/write accumulator threshold in result format
// - Optional interrupt only after result count limit
// - Result counter reports completed conversions
package adc_mon_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int THC_W = 8;
   localparam int RCL_W = 16;
   localparam int STAT_W = 6;
   localparam int CFG_W = 6;
   localparam int BE_W = 4;

   localparam logic [ADDR_W-1:0] OFF_RCL = 32'h40030048;
   localparam logic [ADDR_W-1:0] OFF_RCV = 32'h4003004c;
   localparam logic [ADDR_W-1:0] OFF_TH = 32'h40030050;
   localparam logic [ADDR_W-1:0] OFF_THC = 32'h40030054;
   localparam logic [ADDR_W-1:0] OFF_THV = 32'h40030058;
   localparam logic [ADDR_W-1:0] OFF_ACC = 32'h4003005c;
   localparam logic [ADDR_W-1:0] OFF_ATH = 32'h40030060;
   localparam logic [ADDR_W-1:0] OFF_DAT = 32'h40030064;
   localparam logic [ADDR_W-1:0] OFF_STAT = 32'h40030070;
   localparam logic [ADDR_W-1:0] OFF_MASK = 32'h40030074;
   localparam logic [ADDR_W-1:0] OFF_CFG = 32'h40030078;

   localparam int CFG_RC_IRQ_BIT = 0;
   localparam int CFG_ACC_RESTART_BIT = 1;
   localparam int CFG_CODING_BIT = 2;
   localparam int CFG_ACC_EN_BIT = 5;

   localparam int STAT_RC_BIT = 0;
   localparam int STAT_THEX_BIT = 4;
   localparam int STAT_ACC_BIT = 5;

   localparam logic [DATA_W-1:0] TH_RST = 32'h00000000;
   localparam logic [THC_W-1:0] THC_RST = 8'h01;
   localparam logic [RCL_W-1:0] RCL_RST = 16'h0001;
   localparam logic [DATA_W-1:0] ATH_RST = 32'h00000000;
   localparam logic [DATA_W-1:0] ACC_RST = 32'h00000000;
   localparam logic [DATA_W-1:0] DAT_RST = 32'h00000000;
   localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
   localparam logic [STAT_W-1:0] MASK_RST = 6'h00;
   localparam logic [STAT_W-1:0] STAT_RST = 6'h00;
   localparam logic [DATA_W-1:0] RD_UNMAPPED = 32'h00000000;

   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } conv_t;
endpackage : adc_mon_pkg

// file: limit_counter.sv
// Event counter that restarts at zero when it reaches a programmed limit
`timescale 1ns/1ns
module limit_counter #(
   parameter int W = 8
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_clear,
   input wire logic i_inc,
   input wire logic [W-1:0] i_limit,
   output logic [W-1:0] o_count,
   output logic o_hit
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   assign count_nxt = W'(count_r + 1'b1);
   // A limit of zero behaves as one: every event hits
   assign o_hit = i_inc & (count_nxt >= i_limit);
   assign o_count = count_r;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         count_r <= '0;
      end else if (i_clear) begin
         count_r <= '0;
      end else if (o_hit) begin
         count_r <= '0;
      end else if (i_inc) begin
         count_r <= count_nxt;
      end
   end
endmodule : limit_counter

// file: adc_threshold_accumulator.sv
// Threshold comparator, counters and accumulator on the conversion results
`timescale 1ns/1ns
module adc_threshold_accumulator (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [adc_mon_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [adc_mon_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [adc_mon_pkg::BE_W-1:0] i_avs_byteenable,
   output logic [adc_mon_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire adc_mon_pkg::conv_t i_conv,
   input wire logic i_adc_reconfig,
   output logic o_irq
);
   import adc_mon_pkg::*;

   logic ack_r;
   logic req;
   logic wr_en;
   logic [DATA_W-1:0] readdata_r;
   logic [DATA_W-1:0] rd_mux;
   logic rd_take;
   logic wr_th;
   logic wr_thc;
   logic wr_ath;
   logic wr_rcl;
   logic wr_cfg;
   logic wr_mask;
   logic wr_stat;

   logic [DATA_W-1:0] abs_compare_threshold_r;
   logic [THC_W-1:0] exceed_count_limit_r;
   logic [DATA_W-1:0] accumulator_threshold_r;
   logic [RCL_W-1:0] result_count_limit_r;
   logic [CFG_W-1:0] converter_config_r;
   logic [STAT_W-1:0] converter_irq_mask_r;
   logic [STAT_W-1:0] converter_status_r;
   logic [STAT_W-1:0] status_nxt;
   logic [STAT_W-1:0] status_clr;
   logic [STAT_W-1:0] status_set;
   logic [DATA_W-1:0] result_accumulator_r;
   logic [DATA_W-1:0] acc_nxt;
   logic [DATA_W-1:0] conversion_result_r;
   logic restart_r;

   logic [THC_W-1:0] exceed_count_value;
   logic [RCL_W-1:0] result_count_value;
   logic exceed_hit;
   logic rc_hit;
   logic exceeded;
   logic acc_over;
   logic acc_en;
   logic coding_signed;
   logic acc_clear;
   logic restart_en;
   logic rc_irq_mode;
   logic [DATA_W-1:0] abs_th;
   logic [DATA_W-1:0] res_mag;

   // Byte-lane merge of a write into a stored word
   function automatic logic [DATA_W-1:0] be_merge(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] wd,
      input logic [BE_W-1:0] be
   );
      logic [DATA_W-1:0] res;
      res = old;
      for (int i = 0; i < BE_W; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return res;
   endfunction : be_merge

   // Magnitude of a value, treating it as signed only when asked
   function automatic logic [DATA_W-1:0] magnitude(
      input logic [DATA_W-1:0] v,
      input logic sgn
   );
      logic [DATA_W-1:0] res;
      res = v;
      if (sgn && v[DATA_W-1]) begin
         res = DATA_W'(~v + 1'b1);
      end
      return res;
   endfunction : magnitude

   // Bus slave: one wait cycle, then the answer; read data is sampled in
   // the wait cycle so it cannot change while the master holds the request
   assign req = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_r;
   assign wr_en = i_avs_write & ack_r;
   assign o_avs_readdata = readdata_r;
   assign rd_take = i_avs_read & ~ack_r;

   // One strobe per writable offset; read-only offsets have none
   assign wr_th = wr_en & (i_avs_address == OFF_TH);
   assign wr_thc = wr_en & (i_avs_address == OFF_THC);
   assign wr_ath = wr_en & (i_avs_address == OFF_ATH);
   assign wr_rcl = wr_en & (i_avs_address == OFF_RCL);
   assign wr_cfg = wr_en & (i_avs_address == OFF_CFG);
   assign wr_mask = wr_en & (i_avs_address == OFF_MASK);
   assign wr_stat = wr_en & (i_avs_address == OFF_STAT);

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ack_r <= 1'b0;
      end else if (ack_r) begin
         ack_r <= 1'b0;
      end else if (req) begin
         ack_r <= 1'b1;
      end
   end

   always_comb begin
      case (i_avs_address)
         OFF_RCL: rd_mux = DATA_W'(result_count_limit_r);
         OFF_RCV: rd_mux = DATA_W'(result_count_value);
         OFF_TH: rd_mux = abs_compare_threshold_r;
         OFF_THC: rd_mux = DATA_W'(exceed_count_limit_r);
         OFF_THV: rd_mux = DATA_W'(exceed_count_value);
         OFF_ACC: rd_mux = result_accumulator_r;
         OFF_ATH: rd_mux = accumulator_threshold_r;
         OFF_DAT: rd_mux = conversion_result_r;
         OFF_STAT: rd_mux = DATA_W'(converter_status_r);
         OFF_MASK: rd_mux = DATA_W'(converter_irq_mask_r);
         OFF_CFG: rd_mux = DATA_W'(converter_config_r);
         default: rd_mux = RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         readdata_r <= RD_UNMAPPED;
      end else if (rd_take) begin
         readdata_r <= rd_mux;
      end
   end

   // Writable registers; the accumulator offset has no write path
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         abs_compare_threshold_r <= TH_RST;
      end else if (wr_th) begin
         abs_compare_threshold_r <= be_merge(abs_compare_threshold_r,
            i_avs_writedata, i_avs_byteenable);
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         exceed_count_limit_r <= THC_RST;
      end else if (wr_thc) begin
         exceed_count_limit_r <= THC_W'(be_merge(DATA_W'(exceed_count_limit_r),
            i_avs_writedata, i_avs_byteenable));
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         accumulator_threshold_r <= ATH_RST;
      end else if (wr_ath) begin
         accumulator_threshold_r <= be_merge(accumulator_threshold_r,
            i_avs_writedata, i_avs_byteenable);
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         result_count_limit_r <= RCL_RST;
      end else if (wr_rcl) begin
         result_count_limit_r <= RCL_W'(be_merge(DATA_W'(result_count_limit_r),
            i_avs_writedata, i_avs_byteenable));
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         converter_config_r <= CFG_RST;
      end else if (wr_cfg) begin
         converter_config_r <= CFG_W'(be_merge(DATA_W'(converter_config_r),
            i_avs_writedata, i_avs_byteenable));
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         converter_irq_mask_r <= MASK_RST;
      end else if (wr_mask) begin
         converter_irq_mask_r <= STAT_W'(be_merge(
            DATA_W'(converter_irq_mask_r), i_avs_writedata,
            i_avs_byteenable));
      end
   end

   assign acc_en = converter_config_r[CFG_ACC_EN_BIT];
   assign coding_signed = converter_config_r[CFG_CODING_BIT];
   assign restart_en = converter_config_r[CFG_ACC_RESTART_BIT];
   assign rc_irq_mode = converter_config_r[CFG_RC_IRQ_BIT];
   // Disable clears at once; holding it low a whole conversion is on software
   assign acc_clear = i_adc_reconfig | ~acc_en;

   // Threshold comparison on magnitudes
   assign abs_th = magnitude(abs_compare_threshold_r, 1'b1);
   assign res_mag = magnitude(i_conv.data, coding_signed);
   assign exceeded = i_conv.valid & (res_mag > abs_th);

   limit_counter #(
      .W(THC_W)
   ) u_exceed_cnt (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_clear(i_adc_reconfig),
      .i_inc(exceeded),
      .i_limit(exceed_count_limit_r),
      .o_count(exceed_count_value),
      .o_hit(exceed_hit)
   );

   limit_counter #(
      .W(RCL_W)
   ) u_result_cnt (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_clear(i_adc_reconfig),
      .i_inc(i_conv.valid),
      .i_limit(result_count_limit_r),
      .o_count(result_count_value),
      .o_hit(rc_hit)
   );

   // Accumulator: plain modular add, no overflow detection
   assign acc_nxt = restart_r ? i_conv.data
      : DATA_W'(result_accumulator_r + i_conv.data);

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         result_accumulator_r <= ACC_RST;
      end else if (acc_clear) begin
         result_accumulator_r <= ACC_RST;
      end else if (i_conv.valid) begin
         result_accumulator_r <= acc_nxt;
      end
   end

   // Restart after the limit sample so software can still read a full sum
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         restart_r <= 1'b0;
      end else if (acc_clear) begin
         restart_r <= 1'b0;
      end else if (rc_hit && restart_en) begin
         restart_r <= 1'b1;
      end else if (i_conv.valid) begin
         restart_r <= 1'b0;
      end
   end

   // Result register loads on the same edge as the accumulator
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         conversion_result_r <= DAT_RST;
      end else if (i_conv.valid) begin
         conversion_result_r <= i_conv.data;
      end
   end

   // Accumulator threshold crossing, compared in the coding format
   always_comb begin
      if (coding_signed) begin
         acc_over = $signed(acc_nxt) > $signed(accumulator_threshold_r);
      end else begin
         acc_over = acc_nxt > accumulator_threshold_r;
      end
   end

   // Sticky status, write one to clear; a new event wins over the clear
   always_comb begin
      status_set = '0;
      status_set[STAT_THEX_BIT] = exceed_hit;
      status_set[STAT_RC_BIT] = rc_irq_mode
         ? rc_hit : i_conv.valid;
      status_set[STAT_ACC_BIT] = i_conv.valid & ~acc_clear & acc_over;
      status_clr = '0;
      if (wr_stat && i_avs_byteenable[0]) begin
         status_clr = i_avs_writedata[STAT_W-1:0];
      end
      status_nxt = (converter_status_r & ~status_clr) | status_set;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         converter_status_r <= STAT_RST;
      end else begin
         converter_status_r <= status_nxt;
      end
   end

   // Mask bit 5 is the software's to drop when the accumulator is off
   assign o_irq = |(converter_status_r & converter_irq_mask_r);
endmodule : adc_threshold_accumulator

// file: adc_mon_monitor.sv
// Port-level checks on the conversion-result monitor
`timescale 1ns/1ns
module adc_mon_monitor
   import adc_mon_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [adc_mon_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [adc_mon_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [adc_mon_pkg::BE_W-1:0] i_avs_byteenable,
   input wire logic [adc_mon_pkg::DATA_W-1:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire adc_mon_pkg::conv_t i_conv,
   input wire logic i_adc_reconfig,
   input wire logic o_irq
);
   logic rq;
   assign rq = i_avs_read | i_avs_write;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   AST_IDLE_NOWAIT: assert property (!rq |-> !o_avs_waitrequest)
      else $error("wait raised while idle");
   AST_WAIT_FIRST: assert property ($rose(rq) |-> o_avs_waitrequest)
      else $error("no wait cycle");
   AST_WAIT_ONE: assert property (rq && o_avs_waitrequest |=>
      !o_avs_waitrequest) else $error("wait longer than one cycle");
   AST_RD_HOLD: assert property (!i_avs_read |=>
      $stable(o_avs_readdata)) else $error("readdata moved");
   AST_RD_UNMAP: assert property (i_avs_read && o_avs_waitrequest &&
      i_avs_address[1:0] != 2'h0 |=> o_avs_readdata == RD_UNMAPPED)
      else $error("unmapped read not zero");
   AST_THV_WIDTH: assert property (i_avs_read && o_avs_waitrequest &&
      i_avs_address == OFF_THV |=> o_avs_readdata[31:8] == 24'h000000)
      else $error("counter upper bits set");
   AST_IRQ_RISE: assert property ($rose(o_irq) |-> $past(i_conv.valid)
      || $past(i_avs_write) || $past(i_adc_reconfig))
      else $error("irq rose without cause");
   AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(i_avs_write))
      else $error("irq fell without write");
   cover property (rq ##1 !o_avs_waitrequest);
   cover property ($rose(o_irq));
   cover property ($fell(o_irq));
endmodule : adc_mon_monitor

bind adc_threshold_accumulator adc_mon_monitor adc_mon_monitor_inst (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_conv(i_conv), .i_adc_reconfig(i_adc_reconfig), .o_irq(o_irq));

// file: conv_source.sv
// Conversion result source, one result per call
`timescale 1ns/1ns
module conv_source
   import adc_mon_pkg::*;
(
   input wire logic i_clk,
   output adc_mon_pkg::conv_t o_conv
);
   initial o_conv = '0;
   // Data flips after the pulse so a stale value is never re-added
   task automatic send(input logic [DATA_W-1:0] d);
      o_conv <= '{valid: 1'b1, data: d};
      @(posedge i_clk);
      o_conv <= '{valid: 1'b0, data: ~d};
      @(posedge i_clk);
   endtask : send
endmodule : conv_source

// file: tb_top.sv
// Register, threshold and accumulator tests for the monitor
`timescale 1ns/1ns
module tb_top;
   import adc_mon_pkg::*;
   logic i_clk, i_resetn, i_avs_read, i_avs_write, i_adc_reconfig, o_irq;
   logic [ADDR_W-1:0] i_avs_address;
   logic [DATA_W-1:0] i_avs_writedata, o_avs_readdata;
   logic [BE_W-1:0] i_avs_byteenable;
   logic o_avs_waitrequest;
   conv_t i_conv;
   int miscompares, tests_run;
   adc_threshold_accumulator adc_threshold_accumulator_inst (.i_clk(i_clk),
      .i_resetn(i_resetn), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_conv(i_conv), .i_adc_reconfig(i_adc_reconfig), .o_irq(o_irq));
   conv_source conv_source_inst (.i_clk(i_clk), .o_conv(i_conv));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask : chk
   // Hold the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [31:0] a, d,
                      output logic [31:0] q);
      int n;
      n = 0;
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= w;
      i_avs_read <= !w;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 20);
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      if (o_avs_waitrequest !== 1'b0) begin
         $display("Error waitrequest expected 0 seen %b", o_avs_waitrequest);
         miscompares++;
         tally_and_finish();
      end else begin
         q = o_avs_readdata;
         @(posedge i_clk);
      end
   endtask : bus
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [31:0] a, e, input string n);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(n, e, q);
   endtask : rd
   task automatic sd(input logic [31:0] d);
      conv_source_inst.send(d);
   endtask : sd
   task automatic rc;
      i_adc_reconfig <= 1'b1;
      @(posedge i_clk);
      i_adc_reconfig <= 1'b0;
      @(posedge i_clk);
   endtask : rc
   task automatic irq_is(input logic e);
      @(negedge i_clk);
      chk("irq", {31'h0, e}, {31'h0, o_irq});
      @(posedge i_clk);
   endtask : irq_is
   initial begin
      i_resetn = 1'b0;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_address = '0;
      i_avs_writedata = '0;
      i_avs_byteenable = 4'hf;
      i_adc_reconfig = 1'b0;
      miscompares = 0;
      tests_run = 0;
      repeat (5) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      rd(OFF_TH, 32'h0, "th");
      rd(OFF_THC, 32'h1, "thc");
      rd(OFF_THV, 32'h0, "thv");
      rd(OFF_ACC, 32'h0, "acc");
      rd(OFF_ATH, 32'h0, "ath");
      wr(OFF_ATH, 32'h80000001);
      rd(OFF_ATH, 32'h80000001, "ath");
      wr(OFF_ACC, 32'h00001234);
      rd(OFF_ACC, 32'h0, "acc ro");
      rd(OFF_TH + 32'h1, RD_UNMAPPED, "unmapped");
      // Threshold of minus ten: only magnitudes above ten count
      wr(OFF_TH, 32'hfffffff6);
      wr(OFF_THC, 32'h3);
      wr(OFF_CFG, 32'h24);
      wr(OFF_MASK, 32'h10);
      sd(32'ha);
      sd(32'hfffffff5);
      sd(32'hb);
      sd(32'h5);
      rd(OFF_THV, 32'h2, "thv");
      sd(32'h14);
      irq_is(1'b1);
      rd(OFF_THV, 32'h0, "thv hit");
      rd(OFF_STAT, 32'h31, "stat");
      rd(OFF_ACC, 32'h23, "acc sum");
      rd(OFF_DAT, 32'h14, "dat");
      wr(OFF_MASK, 32'h0);
      irq_is(1'b0);
      wr(OFF_MASK, 32'h10);
      irq_is(1'b1);
      wr(OFF_STAT, 32'h3f);
      irq_is(1'b0);
      // Unipolar compare and wrap past 2^32
      wr(OFF_ATH, 32'h7fffffff);
      rc();
      rd(OFF_ACC, 32'h0, "acc rc");
      wr(OFF_CFG, 32'h20);
      wr(OFF_STAT, 32'h3f);
      sd(32'hfffffff0);
      rd(OFF_STAT, 32'h21, "stat uni");
      wr(OFF_STAT, 32'h3f);
      sd(32'h20);
      rd(OFF_STAT, 32'h01, "stat wrap");
      rd(OFF_ACC, 32'h10, "acc wrap");
      rc();
      wr(OFF_CFG, 32'h24);
      wr(OFF_STAT, 32'h3f);
      sd(32'hfffffff0);
      rd(OFF_STAT, 32'h01, "stat sgn");
      rd(OFF_ACC, 32'hfffffff0, "acc sgn");
      // Enable held low across a whole conversion
      wr(OFF_CFG, 32'h04);
      wr(OFF_MASK, 32'h10);
      sd(32'h7);
      rd(OFF_ACC, 32'h0, "acc off");
      wr(OFF_CFG, 32'h24);
      sd(32'h7);
      rd(OFF_ACC, 32'h7, "acc on");
      // Result count limit of three with restart
      wr(OFF_RCL, 32'h3);
      wr(OFF_CFG, 32'h27);
      rc();
      wr(OFF_STAT, 32'h3f);
      sd(32'h1);
      sd(32'h2);
      rd(OFF_RCV, 32'h2, "rcv");
      rd(OFF_STAT, 32'h0, "stat early");
      sd(32'h4);
      rd(OFF_RCV, 32'h0, "rcv hit");
      rd(OFF_STAT, 32'h01, "stat hit");
      sd(32'h8);
      rd(OFF_ACC, 32'h8, "acc restart");
      rd(OFF_DAT, 32'h8, "dat");
      tally_and_finish();
   end
endmodule : tb_top
